// ---- ttpg_map.vh ----
// constants for the transmit test pattern generator
`ifndef TTPG_MAP_VH
`define TTPG_MAP_VH
`define TTPG_MODE_HI          15
`define TTPG_MODE_LO          13
`define TTPG_MODE_NORMAL      3'h0
`define TTPG_MODE_WAVEFORM    3'h1
`define TTPG_MODE_JIT_MASTER  3'h2
`define TTPG_MODE_JIT_SLAVE   3'h3
`define TTPG_MODE_DISTORTION  3'h4
`define TTPG_SYM_ZERO         3'h0
`define TTPG_SYM_P1           3'h1
`define TTPG_SYM_P2           3'h2
`define TTPG_SYM_M1           3'h7
`define TTPG_SYM_M2           3'h6
`define TTPG_WAVE_LEN         12'h0_780
`define TTPG_WAVE_SEG0_END    12'h0_080
`define TTPG_WAVE_SEG1_END    12'h0_100
`define TTPG_WAVE_SEG2_END    12'h0_180
`define TTPG_WAVE_SEG3_END    12'h0_200
`define TTPG_WAVE_SEG4_END    12'h0_280
`define TTPG_WAVE_SEG5_END    12'h0_300
`define TTPG_WAVE_SEG6_END    12'h0_380
`define TTPG_LFSR_SEED        11'h7_FF
`define TTPG_SYMBOL_NS        8
`endif

// ---- ttpg_lfsr.v ----
// distortion-test scrambler with symbol mapping
`timescale 1ns/10ps
`include "ttpg_map.vh"
module ttpg_lfsr (
   input  wire       clock_i,
   input  wire       sys_rst_i,
   input  wire       ce_i,
   input  wire       load_i,
   output wire [2:0] sym_o
);
   reg  [10:0] scr_reg;
   wire [10:0] scr_next;
   wire        sel_bit_low;
   wire        sel_bit_mid;
   wire        sel_bit_high;
   reg  [2:0]  sym_map;

   assign scr_next     = {scr_reg[9:0], scr_reg[8] ^ scr_reg[10]};  // [R11]
   assign sel_bit_low  = scr_reg[0];                                 // [R12]
   assign sel_bit_mid  = scr_reg[1] ^ scr_reg[4];                    // [R12]
   assign sel_bit_high = scr_reg[2] ^ scr_reg[4];                    // [R12]

   always @* begin
      case ({sel_bit_high, sel_bit_mid, sel_bit_low})                // [R13]
         3'h0: sym_map = `TTPG_SYM_ZERO;
         3'h1: sym_map = `TTPG_SYM_P1;
         3'h2: sym_map = `TTPG_SYM_P2;
         3'h3: sym_map = `TTPG_SYM_M1;
         3'h4: sym_map = `TTPG_SYM_ZERO;
         3'h5: sym_map = `TTPG_SYM_P1;
         3'h6: sym_map = `TTPG_SYM_M2;
         default: sym_map = `TTPG_SYM_M1;
      endcase
   end
   assign sym_o = sym_map;

   // nonzero seed on every entry keeps the register out of the dead state
   always @(posedge clock_i) begin
      if (sys_rst_i) begin
         scr_reg <= `TTPG_LFSR_SEED;
      end else if (ce_i) begin
         if (load_i) begin
            scr_reg <= `TTPG_LFSR_SEED;                              // [R16]
         end else begin
            scr_reg <= scr_next;                                     // [R10]
         end
      end
   end
endmodule // ttpg_lfsr

// ---- ttpg_top.v ----
// transmit test mode pattern generator, four pairs
// What this block does
// R1 - test mode comes from bits 15..13 of the gigabit control word
// R2 - decode 000 normal, 001 waveform, 010/011 jitter, 100 distortion, rest reserved
// R3 - test modes replace only the data symbols sent to transmitters
// R4 - a direct mode input allows test modes without management access
// R5 - waveform: +2,-2,-1 pulses each with 127 zeros, 128-blocks, 1024 zeros
// R6 - waveform sequence repeats with no gap
// R7 - waveform, master jitter and distortion use the local master clock
// R8 - master jitter sends +2,-2 repeatedly on every pair
// R9 - slave jitter sends +2,-2 repeatedly, timed by recovered slave clock
// R10 - distortion register is 11 bits, 1+x^9+x^11, advances once per symbol
// R11 - new bit 0 is bit 8 xor bit 10 after shift
// R12 - selectors: x0=bit0, x1=bit1^bit4, x2=bit2^bit4
// R13 - selectors map to quinary symbols per fixed table
// R14 - distortion symbol is identical on all four pairs
// R15 - symbol clock made observable with an enable control
// R16 - distortion register seeded nonzero on mode entry
// R17 - each mode starts at its first symbol; reserved codes act as normal
`timescale 1ns/10ps
`include "ttpg_map.vh"
module ttpg_top #(
   parameter SYM_W = 3
) (
   input  wire             clock_i,
   input  wire             sys_rst_i,
   input  wire             ce_i,
   input  wire [15:0]      gig_ctrl_i,
   input  wire             mgmt_present_i,
   input  wire [2:0]       alt_mode_i,
   input  wire             slave_clk_sel_i,
   input  wire             tclk_out_en_i,
   input  wire             master_tclk_i,
   input  wire             slave_tclk_i,
   input  wire [SYM_W-1:0] norm_sym_a_i,
   input  wire [SYM_W-1:0] norm_sym_b_i,
   input  wire [SYM_W-1:0] norm_sym_c_i,
   input  wire [SYM_W-1:0] norm_sym_d_i,
   output reg  [SYM_W-1:0] tx_sym_a_o,
   output reg  [SYM_W-1:0] tx_sym_b_o,
   output reg  [SYM_W-1:0] tx_sym_c_o,
   output reg  [SYM_W-1:0] tx_sym_d_o,
   output wire             use_slave_timing_o,
   output wire             test_active_o,
   output wire             tx_symbol_clock_out_o
);
   localparam ST_NORMAL = 5'b00001;
   localparam ST_WAVE   = 5'b00010;
   localparam ST_JITM   = 5'b00100;
   localparam ST_JITS   = 5'b01000;
   localparam ST_DIST   = 5'b10000;

   reg  [4:0]  state_reg;
   reg  [4:0]  state_next;
   reg  [11:0] wave_cnt_reg;
   reg         jit_ph_reg;
   wire [2:0]  mode_code;
   wire [2:0]  lfsr_sym;
   wire        mode_change;
   reg  [2:0]  wave_sym;
   reg  [2:0]  pat_sym;
   wire [11:0] wave_cnt_inc;

   // maps the 3-bit mode code to a one-hot state; reserved codes fall to normal
   function [4:0] ttpg_decode;
      input [2:0] code;
      begin
         case (code)                                                 // [R2]
            `TTPG_MODE_WAVEFORM:   ttpg_decode = ST_WAVE;
            `TTPG_MODE_JIT_MASTER: ttpg_decode = ST_JITM;
            `TTPG_MODE_JIT_SLAVE:  ttpg_decode = ST_JITS;
            `TTPG_MODE_DISTORTION: ttpg_decode = ST_DIST;
            default:               ttpg_decode = ST_NORMAL;          // [R17]
         endcase
      end
   endfunction

   // without management access, the strap-like input picks the mode
   assign mode_code = mgmt_present_i ? gig_ctrl_i[`TTPG_MODE_HI:`TTPG_MODE_LO]   // [R1]
                                     : alt_mode_i;                               // [R4]

   always @* begin
      state_next = ttpg_decode(mode_code);
   end
   assign mode_change = (state_next != state_reg);

   ttpg_lfsr u_lfsr (
      .clock_i   (clock_i),
      .sys_rst_i (sys_rst_i),
      .ce_i      (ce_i),
      .load_i    (mode_change),                                      // [R16]
      .sym_o     (lfsr_sym)
   );

   assign wave_cnt_inc = wave_cnt_reg + 12'h0_001;

   always @(posedge clock_i) begin
      if (sys_rst_i) begin
         state_reg    <= ST_NORMAL;
         wave_cnt_reg <= 12'h0_000;
         jit_ph_reg   <= 1'b0;
      end else if (ce_i) begin
         state_reg <= state_next;
         if (mode_change) begin
            wave_cnt_reg <= 12'h0_000;                               // [R17]
            jit_ph_reg   <= 1'b0;                                    // [R17]
         end else begin
            if (wave_cnt_inc == `TTPG_WAVE_LEN) begin
               wave_cnt_reg <= 12'h0_000;                            // [R6]
            end else begin
               wave_cnt_reg <= wave_cnt_inc;
            end
            jit_ph_reg <= ~jit_ph_reg;
         end
      end
   end

   // waveform: three lone pulses, four 128-wide blocks, then 1024 zeros
   always @* begin
      wave_sym = `TTPG_SYM_ZERO;                                     // [R5]
      if (wave_cnt_reg == 12'h0_000) begin
         wave_sym = `TTPG_SYM_P2;
      end else if (wave_cnt_reg == `TTPG_WAVE_SEG0_END) begin
         wave_sym = `TTPG_SYM_M2;
      end else if (wave_cnt_reg == `TTPG_WAVE_SEG1_END) begin
         wave_sym = `TTPG_SYM_M1;
      end else if (wave_cnt_reg >= `TTPG_WAVE_SEG2_END &&
                   wave_cnt_reg <  `TTPG_WAVE_SEG3_END) begin
         wave_sym = `TTPG_SYM_P2;
      end else if (wave_cnt_reg >= `TTPG_WAVE_SEG3_END &&
                   wave_cnt_reg <  `TTPG_WAVE_SEG4_END) begin
         wave_sym = `TTPG_SYM_M2;
      end else if (wave_cnt_reg >= `TTPG_WAVE_SEG4_END &&
                   wave_cnt_reg <  `TTPG_WAVE_SEG5_END) begin
         wave_sym = `TTPG_SYM_P2;
      end else if (wave_cnt_reg >= `TTPG_WAVE_SEG5_END &&
                   wave_cnt_reg <  `TTPG_WAVE_SEG6_END) begin
         wave_sym = `TTPG_SYM_M2;
      end
   end

   always @* begin
      case (state_reg)
         ST_WAVE: pat_sym = wave_sym;
         ST_JITM: pat_sym = jit_ph_reg ? `TTPG_SYM_M2 : `TTPG_SYM_P2;  // [R8]
         ST_JITS: pat_sym = jit_ph_reg ? `TTPG_SYM_M2 : `TTPG_SYM_P2;  // [R9]
         default: pat_sym = lfsr_sym;
      endcase
   end

   // only the symbol values are swapped; timing path to the drivers is untouched
   always @(posedge clock_i) begin
      if (sys_rst_i) begin
         tx_sym_a_o <= {SYM_W{1'b0}};
         tx_sym_b_o <= {SYM_W{1'b0}};
         tx_sym_c_o <= {SYM_W{1'b0}};
         tx_sym_d_o <= {SYM_W{1'b0}};
      end else if (ce_i) begin
         if (state_reg == ST_NORMAL || mode_change) begin           // [R3]
            tx_sym_a_o <= norm_sym_a_i;
            tx_sym_b_o <= norm_sym_b_i;
            tx_sym_c_o <= norm_sym_c_i;
            tx_sym_d_o <= norm_sym_d_i;
         end else begin
            tx_sym_a_o <= pat_sym;                                   // [R14]
            tx_sym_b_o <= pat_sym;
            tx_sym_c_o <= pat_sym;
            tx_sym_d_o <= pat_sym;
         end
      end
   end

   // slave timing forced for the slave jitter test; other test modes run on local reference, normal follows slave_clk_sel_i
   assign use_slave_timing_o = (state_reg == ST_JITS) ? 1'b1 :      // [R9]
                               (state_reg == ST_NORMAL) ? slave_clk_sel_i :
                               1'b0;                                 // [R7]
   assign test_active_o      = (state_reg != ST_NORMAL);
   // gated copy of the symbol clock; enable must change while clocks are quiet
   assign tx_symbol_clock_out_o = tclk_out_en_i &                    // [R15]
                                  (use_slave_timing_o ? slave_tclk_i : master_tclk_i);
endmodule // ttpg_top

// ---- ttpg_monitor.sv ----
// assertion checker for the transmit test pattern generator
`timescale 1ns/10ps
`include "ttpg_map.vh"
module ttpg_monitor #(
   parameter SYM_W = 3
) (
   input wire             clock_i,
   input wire             sys_rst_i,
   input wire             ce_i,
   input wire [15:0]      gig_ctrl_i,
   input wire             mgmt_present_i,
   input wire [2:0]       alt_mode_i,
   input wire             slave_clk_sel_i,
   input wire             tclk_out_en_i,
   input wire             master_tclk_i,
   input wire             slave_tclk_i,
   input wire [SYM_W-1:0] norm_sym_a_i,
   input wire [SYM_W-1:0] tx_sym_a_o,
   input wire [SYM_W-1:0] tx_sym_b_o,
   input wire [SYM_W-1:0] tx_sym_c_o,
   input wire [SYM_W-1:0] tx_sym_d_o,
   input wire             use_slave_timing_o,
   input wire             test_active_o,
   input wire             tx_symbol_clock_out_o
);
   wire [2:0]  md  = mgmt_present_i ? gig_ctrl_i[15:13] : alt_mode_i;
   wire        act = (md != 3'h0) && (md < 3'h5);
   reg  [2:0]  md_q;
   reg  [11:0] run;
   // run counts enabled edges with an unchanged mode, so patterns are judged only once settled
   always @(posedge clock_i) begin
      md_q <= md;
      if (sys_rst_i || !ce_i || md != md_q) run <= 12'h000;
      else if (run != 12'hFFF) run <= run + 12'h001;
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   a_pairs_equal: assert property (
      test_active_o && run >= 12'h002 |-> tx_sym_b_o == tx_sym_a_o &&
      tx_sym_c_o == tx_sym_a_o && tx_sym_d_o == tx_sym_a_o) else $error("pairs differ");
   a_mode_decode: assert property (
      ce_i |=> test_active_o == $past(act)) else $error("mode decode wrong");
   a_slave_timing: assert property (
      ce_i |=> use_slave_timing_o == ($past(md) == 3'h3 || (!$past(act) && slave_clk_sel_i)))
      else $error("timing source wrong");
   a_clock_out: assert property (
      tx_symbol_clock_out_o == (tclk_out_en_i && (use_slave_timing_o ? slave_tclk_i : master_tclk_i)))
      else $error("symbol clock output wrong");
   a_jitter_toggle: assert property (
      run >= 12'h004 && md_q[2:1] == 2'b01 |-> tx_sym_a_o != $past(tx_sym_a_o) &&
      tx_sym_a_o[1] && !tx_sym_a_o[0]) else $error("jitter pattern broken");
   a_wave_first: assert property (
      ce_i && md == `TTPG_MODE_WAVEFORM && !test_active_o ##1 ce_i && md == `TTPG_MODE_WAVEFORM
      |=> tx_sym_a_o == `TTPG_SYM_P2) else $error("waveform start wrong");
   a_wave_repeat: assert property (
      run >= 12'h784 && md_q == `TTPG_MODE_WAVEFORM |-> tx_sym_a_o == $past(tx_sym_a_o, 1920))
      else $error("waveform period wrong");
   a_normal_pass: assert property (
      ce_i && !test_active_o |=> tx_sym_a_o == $past(norm_sym_a_i)) else $error("normal symbol lost");
   c_wave_cycle: cover property (run >= 12'h784 && md_q == `TTPG_MODE_WAVEFORM);
   c_distortion: cover property (run >= 12'h020 && md_q == `TTPG_MODE_DISTORTION);
   c_slave_jit: cover property (use_slave_timing_o && test_active_o);
endmodule // ttpg_monitor

bind ttpg_top ttpg_monitor #(.SYM_W(SYM_W)) u_mon (.clock_i, .sys_rst_i, .ce_i, .gig_ctrl_i,
   .mgmt_present_i, .alt_mode_i, .slave_clk_sel_i, .tclk_out_en_i, .master_tclk_i, .slave_tclk_i,
   .norm_sym_a_i, .tx_sym_a_o, .tx_sym_b_o, .tx_sym_c_o, .tx_sym_d_o, .use_slave_timing_o,
   .test_active_o, .tx_symbol_clock_out_o);

// ---- ttpg_pair_sink.sv ----
// partner model: the four pair drivers taking symbols
`timescale 1ns/10ps
module ttpg_pair_sink (
   input  wire [2:0] sym_a_i,
   input  wire [2:0] sym_b_i,
   input  wire [2:0] sym_c_i,
   input  wire [2:0] sym_d_i,
   output wire [2:0] line_o,
   output wire       agree_o
);
   // drivers act on codes alone; a spread across pairs is flagged, never corrected
   assign line_o  = sym_a_i;
   assign agree_o = (sym_b_i == sym_a_i) && (sym_c_i == sym_a_i) && (sym_d_i == sym_a_i);
endmodule // ttpg_pair_sink

// ---- tb.sv ----
// self-checking bench for the transmit test pattern generator
`timescale 1ns/10ps
`include "ttpg_map.vh"
module tb;
   localparam [23:0] QMAP = 24'hF8_8E88;
   reg        clock_i     = 1'b0;
   reg        sys_rst_i   = 1'b1;
   reg        mgmt        = 1'b1;
   reg        sel         = 1'b0;
   reg        en          = 1'b0;
   reg        ce          = 1'b1;
   reg [15:0] gig         = 16'h0000;
   reg [2:0]  alt         = 3'h0;
   reg [2:0]  nsym        = 3'h0;
   reg [7:0]  r;
   reg        xs;
   reg [7:0]  rows [0:7]  = '{8'h01, 8'h32, 8'h52, 8'h7A, 8'h91, 8'hA7, 8'hC6, 8'hE2};
   wire [2:0] tx_a, tx_b, tx_c, tx_d, line;
   wire       slv, act, tclk, agree;
   integer    miscompares = 0;
   integer    n_compared  = 0;
   integer    i;
   ttpg_top u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .gig_ctrl_i(gig),
      .mgmt_present_i(mgmt), .alt_mode_i(alt), .slave_clk_sel_i(sel), .tclk_out_en_i(en),
      .master_tclk_i(1'b1), .slave_tclk_i(1'b0), .norm_sym_a_i(nsym), .norm_sym_b_i(nsym),
      .norm_sym_c_i(nsym), .norm_sym_d_i(nsym), .tx_sym_a_o(tx_a), .tx_sym_b_o(tx_b),
      .tx_sym_c_o(tx_c), .tx_sym_d_o(tx_d), .use_slave_timing_o(slv), .test_active_o(act),
      .tx_symbol_clock_out_o(tclk));
   ttpg_pair_sink u_sink (.sym_a_i(tx_a), .sym_b_i(tx_b), .sym_c_i(tx_c), .sym_d_i(tx_d),
      .line_o(line), .agree_o(agree));
   initial forever #25 clock_i = ~clock_i;
   task check(input [2:0] seen, input [2:0] exp);
      n_compared = n_compared + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function [2:0] wave(input integer k);
      if (k == 0 || (k >= 384 && k < 896 && (k - 384) % 256 < 128)) wave = `TTPG_SYM_P2;
      else if (k == 128 || (k >= 384 && k < 896)) wave = `TTPG_SYM_M2;
      else if (k == 256) wave = `TTPG_SYM_M1;
      else wave = `TTPG_SYM_ZERO;
   endfunction
   task run(input [2:0] code, input integer n);
      reg [10:0] s;
      reg [2:0]  e;
      integer    k;
      s = `TTPG_LFSR_SEED;
      mgmt <= 1'b1;
      gig  <= {code, 13'h0000};
      @(posedge clock_i);
      for (k = 0; k < n; k = k + 1) begin
         @(posedge clock_i);
         #1;
         if (code == `TTPG_MODE_WAVEFORM) e = wave(k % 1920);
         else if (code == `TTPG_MODE_DISTORTION) e = QMAP[{s[2]^s[4], s[1]^s[4], s[0]} * 3 +: 3];
         else e = k[0] ? `TTPG_SYM_M2 : `TTPG_SYM_P2;
         s = {s[9:0], s[8] ^ s[10]};
         check(line, e);
         check(agree, 1'b1);
      end
      $display("mode %0d run done", code);
   endtask
   task results;
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (8000) @(posedge clock_i);
      miscompares = miscompares + 1;
      results;
   end
   initial begin
      repeat (2) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      // the unused mode source carries the inverted code, so a wrong pick shows
      for (i = 0; i < 16; i = i + 1) begin
         @(posedge clock_i);
         r = rows[i % 8];
         xs = r[3] | (i[1] & ~r[4]);
         {mgmt, sel, en} <= {i < 8, i[1], i[0]};
         gig  <= {r[7:5] ^ {3{i >= 8}}, 13'h0000};
         alt  <= r[7:5] ^ {3{i < 8}};
         nsym <= r[2:0];
         repeat (2) @(posedge clock_i);
         #1;
         check(act, r[4]);
         check(slv, xs);
         check(line, r[2:0]);
         check(tclk, i[0] & ~xs);
      end
      $display("mode table done");
      run(1, 1925);
      run(2, 6);
      // enable low must freeze the jitter phase, then it resumes where it stopped
      @(posedge clock_i);
      ce <= 1'b0;
      repeat (3) @(posedge clock_i);
      #1;
      check(line, `TTPG_SYM_P2);
      @(posedge clock_i);
      ce <= 1'b1;
      @(posedge clock_i);
      #1;
      check(line, `TTPG_SYM_M2);
      $display("enable freeze done");
      run(4, 40);
      run(3, 6);
      @(posedge clock_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      #1;
      check(act, 1'b0);
      check(line, `TTPG_SYM_ZERO);
      @(posedge clock_i);
      sys_rst_i <= 1'b0;
      run(3, 6);
      results;
   end
endmodule // tb
